//--- tsbs_burner.sv
`timescale 1ns/1ps
`include "tsbs_map.svh"
module tsbs_burner #(
  parameter int unsigned TICK_CYCLES = `TSBS_TICK_CYCLES,
  parameter int unsigned CNT_W = 32
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic RUN_REQUEST,
  input wire logic SECOND_LEVEL_REQUEST,
  input wire logic OVERHEAT,
  input wire logic OIL_THERMOSTAT,
  input wire logic FLAME,
  input wire logic FAULT_RESET,
  input wire logic SERVICE_RESET,
  input wire logic RELIGHT_ALLOWED,
  input wire tsbs_pkg::tsbs_times_t TIMES,
  input wire logic [15:0] LEVEL_ONE_POWER,
  input wire logic [15:0] LEVEL_TWO_POWER,
  output tsbs_pkg::tsbs_drive_t DRIVE,
  output logic [7:0] STATUS,
  output logic FAIL,
  output logic [CNT_W-1:0] LEVEL_ONE_SECONDS,
  output logic [CNT_W-1:0] LEVEL_TWO_SECONDS,
  output logic [CNT_W-1:0] START_COUNT,
  output logic [47:0] ENERGY_TOTAL
);
  initial begin
    if (TICK_CYCLES < 2 || CNT_W < 8 || CNT_W > 48) begin
      $error("tsbs_burner: unsupported parameter values");
    end
  end

  tsbs_pkg::tsbs_state_t state_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [15:0] seq_timer_reg;
  logic [15:0] ign_timer_reg;
  logic [15:0] l2_timer_reg;
  logic [47:0] energy_sub_reg;
  logic flame_seen_reg;

  // Seconds time base
  // fixed tick
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == TICK_CYCLES - 1);

  function automatic logic expired(input logic [15:0] t);
    return (t == 16'h0);
  endfunction

  function automatic logic [15:0] count_down(input logic [15:0] t, input logic tk);
    return (tk && t != 16'h0) ? t - 16'h1 : t;
  endfunction

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= tsbs_pkg::TSBS_IDLE;
      seq_timer_reg <= 16'h0;
      STATUS <= `TSBS_ST_STANDBY;
      FAIL <= 1'b0;
      flame_seen_reg <= 1'b0;
    end else if (OVERHEAT && !(state_reg == tsbs_pkg::TSBS_LOCK && FAIL &&
                 STATUS == `TSBS_ST_OVERHEAT)) begin
      state_reg <= tsbs_pkg::TSBS_LOCK;
      seq_timer_reg <= TIMES.fault_hold_interval;
      STATUS <= `TSBS_ST_OVERHEAT;
      FAIL <= 1'b1;
    end else begin
      case (state_reg)
        tsbs_pkg::TSBS_IDLE: begin
          STATUS <= `TSBS_ST_STANDBY;
          FAIL <= 1'b0;
          flame_seen_reg <= 1'b0;
          if (RUN_REQUEST && !OVERHEAT) begin
            state_reg <= tsbs_pkg::TSBS_PREHEAT;
            seq_timer_reg <= TIMES.preheat;
            STATUS <= `TSBS_ST_STARTUP;
          end
        end
        tsbs_pkg::TSBS_PREHEAT: begin
          seq_timer_reg <= count_down(seq_timer_reg, tick);
          if (!RUN_REQUEST) begin
            state_reg <= tsbs_pkg::TSBS_IDLE;
            STATUS <= `TSBS_ST_STANDBY;
          end else if (FLAME) begin
            state_reg <= tsbs_pkg::TSBS_LOCK;
            seq_timer_reg <= TIMES.fault_hold_interval;
            STATUS <= `TSBS_ST_FLAME_PREHEAT;
            FAIL <= 1'b1;
          end else if (OIL_THERMOSTAT) begin
            state_reg <= tsbs_pkg::TSBS_PURGE;
            seq_timer_reg <= TIMES.prepurge_interval;
          end else if (expired(seq_timer_reg)) begin
            state_reg <= tsbs_pkg::TSBS_LOCK;
            seq_timer_reg <= TIMES.fault_hold_interval;
            STATUS <= `TSBS_ST_PREHEAT_FAIL;
            FAIL <= 1'b1;
          end
        end
        tsbs_pkg::TSBS_PURGE: begin
          seq_timer_reg <= count_down(seq_timer_reg, tick);
          if (!RUN_REQUEST) begin
            state_reg <= tsbs_pkg::TSBS_IDLE;
            STATUS <= `TSBS_ST_STANDBY;
          end else if (FLAME) begin
            state_reg <= tsbs_pkg::TSBS_LOCK;
            seq_timer_reg <= TIMES.fault_hold_interval;
            STATUS <= `TSBS_ST_FLAME_PURGE;
            FAIL <= 1'b1;
          end else if (expired(seq_timer_reg)) begin
            state_reg <= tsbs_pkg::TSBS_PREIGN;
            seq_timer_reg <= TIMES.pre_ignite;
          end
        end
        tsbs_pkg::TSBS_PREIGN: begin
          seq_timer_reg <= count_down(seq_timer_reg, tick);
          if (!RUN_REQUEST) begin
            state_reg <= tsbs_pkg::TSBS_IDLE;
            STATUS <= `TSBS_ST_STANDBY;
          end else if (FLAME && !flame_seen_reg) begin
            state_reg <= tsbs_pkg::TSBS_LOCK;
            seq_timer_reg <= TIMES.fault_hold_interval;
            STATUS <= `TSBS_ST_FLAME_PURGE;
            FAIL <= 1'b1;
          end else if (expired(seq_timer_reg)) begin
            state_reg <= tsbs_pkg::TSBS_SAFETY;
            seq_timer_reg <= TIMES.safety;
          end
        end
        tsbs_pkg::TSBS_SAFETY: begin
          seq_timer_reg <= count_down(seq_timer_reg, tick);
          if (!RUN_REQUEST) begin
            state_reg <= tsbs_pkg::TSBS_IDLE;
            STATUS <= `TSBS_ST_STANDBY;
          end else if (FLAME) begin
            state_reg <= tsbs_pkg::TSBS_RUN;
            flame_seen_reg <= 1'b1;
            STATUS <= `TSBS_ST_LEVEL1;
          end else if (expired(seq_timer_reg)) begin
            state_reg <= tsbs_pkg::TSBS_LOCK;
            seq_timer_reg <= TIMES.fault_hold_interval;
            STATUS <= `TSBS_ST_NO_FLAME;
            FAIL <= 1'b1;
          end
        end
        tsbs_pkg::TSBS_RUN: begin
          STATUS <= DRIVE.valve_level_two ? `TSBS_ST_LEVEL2 : `TSBS_ST_LEVEL1;
          if (!RUN_REQUEST) begin
            state_reg <= tsbs_pkg::TSBS_IDLE;
            flame_seen_reg <= 1'b0;
            STATUS <= `TSBS_ST_STANDBY;
          end else if (!FLAME) begin
            if (RELIGHT_ALLOWED) begin
              state_reg <= tsbs_pkg::TSBS_SAFETY;
              seq_timer_reg <= TIMES.safety;
              STATUS <= `TSBS_ST_STARTUP;
            end else begin
              state_reg <= tsbs_pkg::TSBS_LOCK;
              seq_timer_reg <= TIMES.fault_hold_interval;
              STATUS <= `TSBS_ST_FLAME_LOST;
              FAIL <= 1'b1;
            end
          end
        end
        tsbs_pkg::TSBS_LOCK: begin
          flame_seen_reg <= 1'b0;
          seq_timer_reg <= count_down(seq_timer_reg, tick);
          if (expired(seq_timer_reg) && FAULT_RESET && !OVERHEAT) begin
            state_reg <= tsbs_pkg::TSBS_IDLE;
            STATUS <= `TSBS_ST_STANDBY;
            FAIL <= 1'b0;
          end
        end
        default: begin
          state_reg <= tsbs_pkg::TSBS_IDLE;
          STATUS <= `TSBS_ST_STANDBY;
          FAIL <= 1'b0;
        end
      endcase
    end
  end

  // Ignition hold after flame
  // post ignition
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ign_timer_reg <= 16'h0;
    end else if (state_reg != tsbs_pkg::TSBS_RUN) begin
      ign_timer_reg <= TIMES.post_ignite;
    end else begin
      ign_timer_reg <= count_down(ign_timer_reg, tick);
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      l2_timer_reg <= 16'h0;
    end else if (state_reg != tsbs_pkg::TSBS_RUN || !SECOND_LEVEL_REQUEST) begin
      l2_timer_reg <= TIMES.second_level_delay;
    end else begin
      l2_timer_reg <= count_down(l2_timer_reg, tick);
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DRIVE <= '0;
    end else if (OVERHEAT) begin
      DRIVE <= '0;
    end else begin
      DRIVE.oil_preheat <= state_reg inside {tsbs_pkg::TSBS_PREHEAT, tsbs_pkg::TSBS_PURGE,
        tsbs_pkg::TSBS_PREIGN, tsbs_pkg::TSBS_SAFETY, tsbs_pkg::TSBS_RUN};
      DRIVE.fan_motor <= state_reg inside {tsbs_pkg::TSBS_PURGE, tsbs_pkg::TSBS_PREIGN,
        tsbs_pkg::TSBS_SAFETY, tsbs_pkg::TSBS_RUN};
      DRIVE.ignition <= state_reg inside {tsbs_pkg::TSBS_PREIGN, tsbs_pkg::TSBS_SAFETY} ||
        (state_reg == tsbs_pkg::TSBS_RUN && !expired(ign_timer_reg));
      DRIVE.valve_level_one <= state_reg inside {tsbs_pkg::TSBS_SAFETY, tsbs_pkg::TSBS_RUN};
      DRIVE.valve_level_two <= state_reg == tsbs_pkg::TSBS_RUN && SECOND_LEVEL_REQUEST &&
        expired(l2_timer_reg);
    end
  end

  // Service counters
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LEVEL_ONE_SECONDS <= '0;
      LEVEL_TWO_SECONDS <= '0;
      START_COUNT <= '0;
    end else if (SERVICE_RESET) begin
      LEVEL_ONE_SECONDS <= '0;
      LEVEL_TWO_SECONDS <= '0;
      START_COUNT <= '0;
    end else begin
      if (state_reg == tsbs_pkg::TSBS_IDLE && RUN_REQUEST && !OVERHEAT) begin
        START_COUNT <= START_COUNT + 1'b1;
      end
      if (tick && DRIVE.valve_level_one && !DRIVE.valve_level_two &&
          state_reg == tsbs_pkg::TSBS_RUN) begin
        LEVEL_ONE_SECONDS <= LEVEL_ONE_SECONDS + 1'b1;
      end
      if (tick && DRIVE.valve_level_two && state_reg == tsbs_pkg::TSBS_RUN) begin
        LEVEL_TWO_SECONDS <= LEVEL_TWO_SECONDS + 1'b1;
      end
    end
  end

  // Energy in kW-seconds, rolled into kWh
  logic [47:0] energy_sum;
  assign energy_sum = energy_sub_reg + {32'h0, DRIVE.valve_level_two ? LEVEL_TWO_POWER :
    LEVEL_ONE_POWER};
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      energy_sub_reg <= 48'h0;
      ENERGY_TOTAL <= 48'h0;
    end else if (tick && state_reg == tsbs_pkg::TSBS_RUN) begin
      // High ratings may give several kWh in one second
      energy_sub_reg <= energy_sum % `TSBS_KWS_PER_KWH;
      ENERGY_TOTAL <= ENERGY_TOTAL + energy_sum / `TSBS_KWS_PER_KWH;
    end
  end
endmodule

//--- tsbs_map.svh
`ifndef TSBS_MAP_SVH
`define TSBS_MAP_SVH
`define TSBS_CLK_HZ 40000000
`define TSBS_TICK_MS 1000
`define TSBS_TICK_CYCLES ((`TSBS_CLK_HZ / 1000) * `TSBS_TICK_MS)
`define TSBS_ST_PREHEAT_FAIL 8'h01
`define TSBS_ST_FLAME_PREHEAT 8'h02
`define TSBS_ST_FLAME_PURGE 8'h03
`define TSBS_ST_NO_FLAME 8'h04
`define TSBS_ST_FLAME_LOST 8'h05
`define TSBS_ST_OVERHEAT 8'h09
`define TSBS_ST_STANDBY 8'h6E
`define TSBS_ST_STARTUP 8'h6F
`define TSBS_ST_LEVEL1 8'h70
`define TSBS_ST_LEVEL2 8'h71
`define TSBS_PREHEAT_S 16'h003C
`define TSBS_PREPURGE_S 16'h001E
`define TSBS_PREIGN_S 16'h0005
`define TSBS_POSTIGN_S 16'h0005
`define TSBS_SAFETY_S 16'h0005
`define TSBS_L2DELAY_S 16'h003C
`define TSBS_HOLD_S 16'h003C
`define TSBS_KWS_PER_KWH 48'h0E10
`endif

//--- tsbs_pkg.sv
package tsbs_pkg;
  typedef enum logic [3:0] {
    TSBS_IDLE, TSBS_PREHEAT, TSBS_PURGE, TSBS_PREIGN, TSBS_SAFETY,
    TSBS_RUN, TSBS_LOCK
  } tsbs_state_t;
  typedef struct packed {
    logic fan_motor;
    logic valve_level_one;
    logic valve_level_two;
    logic oil_preheat;
    logic ignition;
  } tsbs_drive_t;
  typedef struct packed {
    logic [15:0] preheat;
    logic [15:0] prepurge_interval;
    logic [15:0] pre_ignite;
    logic [15:0] post_ignite;
    logic [15:0] safety;
    logic [15:0] second_level_delay;
    logic [15:0] fault_hold_interval;
  } tsbs_times_t;
endpackage

//--- tsbs_monitor.sv
`timescale 1ns/1ps
module tsbs_monitor #(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned CNT_W = 32
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic OVERHEAT,
  input wire logic FAULT_RESET,
  input wire logic SERVICE_RESET,
  input wire tsbs_pkg::tsbs_times_t TIMES,
  input wire tsbs_pkg::tsbs_drive_t DRIVE,
  input wire logic [7:0] STATUS,
  input wire logic FAIL,
  input wire logic [CNT_W-1:0] LEVEL_ONE_SECONDS,
  input wire logic [CNT_W-1:0] LEVEL_TWO_SECONDS,
  input wire logic [CNT_W-1:0] START_COUNT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  int fail_len;
  // Consecutive cycles spent in fault
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) fail_len <= 0;
    else fail_len <= FAIL ? fail_len + 1 : 0;
  end
  fault_code_a: assert property (FAIL == (STATUS < 8'h6E))
    else $error("fault flag and status code disagree");
  status_set_a: assert property (!FAIL |-> STATUS inside {[8'h6E:8'h71]})
    else $error("bad status without fault");
  fail_codes_a: assert property (FAIL |-> STATUS inside {[8'h01:8'h05], 8'h09})
    else $error("bad fault code");
  overheat_stop_a: assert property (OVERHEAT [*4] |-> STATUS == 8'h09 && DRIVE == '0)
    else $error("overheat did not stop the burner");
  overheat_block_a: assert property (STATUS == 8'h6E && OVERHEAT |=> STATUS != 8'h6F)
    else $error("start despite overheat");
  valve_order_a: assert property ($rose(DRIVE.valve_level_one) |-> DRIVE.ignition)
    else $error("valve opened without ignition");
  ign_fan_a: assert property ($rose(DRIVE.ignition) |-> DRIVE.fan_motor)
    else $error("ignition without fan");
  second_valve_a: assert property (DRIVE.valve_level_two |-> DRIVE.valve_level_one)
    else $error("valve two without valve one");
  service_clear_a: assert property (SERVICE_RESET |-> ##[1:2] START_COUNT == '0
    && LEVEL_ONE_SECONDS == '0 && LEVEL_TWO_SECONDS == '0)
    else $error("service reset left counters");
  start_step_a: assert property ($changed(START_COUNT) && START_COUNT != '0 |->
    START_COUNT == $past(START_COUNT) + 1'b1 && STATUS == 8'h6F)
    else $error("start counter step wrong");
  seconds_step_a: assert property ($changed(LEVEL_TWO_SECONDS) && LEVEL_TWO_SECONDS != '0
    |-> LEVEL_TWO_SECONDS == $past(LEVEL_TWO_SECONDS) + 1'b1 && $past(DRIVE.valve_level_two)
    && $past(STATUS) inside {8'h70, 8'h71})
    else $error("level two seconds step wrong");
  lockout_a: assert property ($fell(FAIL) |-> ($past(FAULT_RESET) || $past(FAULT_RESET, 2))
    && fail_len >= (TIMES.fault_hold_interval - 1) * TICK_CYCLES)
    else $error("fault cleared early");
  cover property (STATUS == 8'h71);
  cover property ($fell(FAIL));
  cover property (STATUS == 8'h70 ##1 STATUS == 8'h6F);
endmodule

//--- tsbs_field.sv
`timescale 1ns/1ps
module tsbs_field #(
  parameter int LAG = 3
) (
  input wire logic mclk,
  input wire tsbs_pkg::tsbs_drive_t drive,
  input wire logic [2:0] mode,
  output logic oil_ok = 1'b0,
  output logic flame = 1'b0
);
  int lag_cnt = 0;
  // Mode 1 cold oil, 2 flame in preheat, 3 flame in purge, 4 no flame
  always @(posedge mclk) begin
    lag_cnt <= drive.valve_level_one ? lag_cnt + 1 : 0;
    oil_ok <= drive.oil_preheat && mode != 3'h1 && mode != 3'h2;
    case (mode)
      3'h2: flame <= drive.oil_preheat;
      3'h3: flame <= drive.fan_motor && !drive.ignition;
      3'h4: flame <= 1'b0;
      default: flame <= lag_cnt >= LAG;
    endcase
  end
endmodule

//--- two_stage_burner_sequencer_tb_top.sv
`timescale 1ns/1ps
module two_stage_burner_sequencer_tb_top;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic RUN_REQUEST = 1'b0, SECOND_LEVEL_REQUEST = 1'b0, OVERHEAT = 1'b0;
  logic FAULT_RESET = 1'b0, SERVICE_RESET = 1'b0, RELIGHT_ALLOWED = 1'b0;
  logic OIL_THERMOSTAT, FLAME, FAIL;
  logic [2:0] mode = 3'h0;
  logic [15:0] LEVEL_ONE_POWER = 16'h0E10, LEVEL_TWO_POWER = 16'h1C20;
  tsbs_pkg::tsbs_times_t TIMES = '{16'h0004, 16'h0003, 16'h0002, 16'h0002, 16'h0003,
    16'h0002, 16'h0003};
  tsbs_pkg::tsbs_drive_t DRIVE;
  logic [7:0] STATUS;
  logic [15:0] LEVEL_ONE_SECONDS, LEVEL_TWO_SECONDS, START_COUNT;
  logic [47:0] ENERGY_TOTAL;
  int errors = 0, comparisons = 0;
  tsbs_burner #(.TICK_CYCLES(10), .CNT_W(16)) i_dut (
    .MCLK(MCLK), .RESET_N(RESET_N), .RUN_REQUEST(RUN_REQUEST),
    .SECOND_LEVEL_REQUEST(SECOND_LEVEL_REQUEST), .OVERHEAT(OVERHEAT),
    .OIL_THERMOSTAT(OIL_THERMOSTAT), .FLAME(FLAME), .FAULT_RESET(FAULT_RESET),
    .SERVICE_RESET(SERVICE_RESET), .RELIGHT_ALLOWED(RELIGHT_ALLOWED), .TIMES(TIMES),
    .LEVEL_ONE_POWER(LEVEL_ONE_POWER), .LEVEL_TWO_POWER(LEVEL_TWO_POWER), .DRIVE(DRIVE),
    .STATUS(STATUS), .FAIL(FAIL), .LEVEL_ONE_SECONDS(LEVEL_ONE_SECONDS),
    .LEVEL_TWO_SECONDS(LEVEL_TWO_SECONDS), .START_COUNT(START_COUNT),
    .ENERGY_TOTAL(ENERGY_TOTAL));
  tsbs_field #(.LAG(4)) i_field (.mclk(MCLK), .drive(DRIVE), .mode(mode),
    .oil_ok(OIL_THERMOSTAT), .flame(FLAME));
  initial forever #12.5 MCLK = ~MCLK;
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #2;
  endtask
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_status(input logic [7:0] exp, input int lim);
    int n;
    n = 0;
    while (STATUS !== exp && n < lim) begin
      cyc(1);
      n++;
    end
    check("status", STATUS, exp);
  endtask
  task automatic recover();
    RUN_REQUEST = 1'b0;
    mode = 3'h0;
    cyc(50);
    check("locked", FAIL, 1'b1);
    FAULT_RESET = 1'b1;
    cyc(1);
    FAULT_RESET = 1'b0;
    wait_status(8'h6E, 10);
  endtask
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    RESET_N = 1'b1;
    check("status", STATUS, 8'h6E);
    RUN_REQUEST = 1'b1;
    cyc(3);
    check("status", STATUS, 8'h6F);
    check("preheat", DRIVE.oil_preheat, 1'b1);
    check("fan", DRIVE.fan_motor, 1'b0);
    wait_status(8'h70, 300);
    check("valve1", DRIVE.valve_level_one, 1'b1);
    check("ignite", DRIVE.ignition, 1'b1);
    cyc(40);
    check("ignite", DRIVE.ignition, 1'b0);
    SECOND_LEVEL_REQUEST = 1'b1;
    cyc(10);
    check("status", STATUS, 8'h70);
    wait_status(8'h71, 40);
    cyc(2);
    check("valve2", DRIVE.valve_level_two, 1'b1);
    cyc(40);
    RUN_REQUEST = 1'b0;
    SECOND_LEVEL_REQUEST = 1'b0;
    wait_status(8'h6E, 10);
    cyc(20);
    check("l2 time", LEVEL_TWO_SECONDS > 0, 1'b1);
    check("energy", ENERGY_TOTAL, LEVEL_ONE_SECONDS + 2 * LEVEL_TWO_SECONDS);
    check("starts", START_COUNT, 16'h0001);
    $display("normal start done");
    for (int m = 1; m <= 5; m++) begin
      mode = (m == 5) ? 3'h0 : 3'(m);
      RUN_REQUEST = 1'b1;
      if (m == 5) begin
        wait_status(8'h70, 300);
        mode = 3'h4;
      end
      wait_status(8'(m), 300);
      check("fail", FAIL, 1'b1);
      cyc(2);
      if (m == 3) check("valve1", DRIVE.valve_level_one, 1'b0);
      recover();
      $display("fault code %0d done", m);
    end
    RELIGHT_ALLOWED = 1'b1;
    RUN_REQUEST = 1'b1;
    wait_status(8'h70, 300);
    mode = 3'h4;
    wait_status(8'h6F, 10);
    cyc(2);
    check("ignite", DRIVE.ignition, 1'b1);
    mode = 3'h0;
    wait_status(8'h70, 100);
    $display("relight done");
    OVERHEAT = 1'b1;
    wait_status(8'h09, 5);
    cyc(3);
    check("drive", DRIVE, 5'h00);
    OVERHEAT = 1'b0;
    recover();
    $display("overheat done");
    check("starts", START_COUNT, 16'h0007);
    SERVICE_RESET = 1'b1;
    cyc(2);
    SERVICE_RESET = 1'b0;
    check("starts", START_COUNT, 16'h0000);
    check("l1 time", LEVEL_ONE_SECONDS, 16'h0000);
    check("l2 time", LEVEL_TWO_SECONDS, 16'h0000);
    $display("service reset done");
    conclude();
  end
  initial begin
    repeat (4000) @(posedge MCLK);
    errors++;
    conclude();
  end
endmodule
bind tsbs_burner tsbs_monitor #(.TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W)) i_mon (
  .MCLK(MCLK), .RESET_N(RESET_N), .OVERHEAT(OVERHEAT), .FAULT_RESET(FAULT_RESET),
  .SERVICE_RESET(SERVICE_RESET), .TIMES(TIMES), .DRIVE(DRIVE), .STATUS(STATUS),
  .FAIL(FAIL), .LEVEL_ONE_SECONDS(LEVEL_ONE_SECONDS), .LEVEL_TWO_SECONDS(LEVEL_TWO_SECONDS),
  .START_COUNT(START_COUNT));
